//--- hdl/srs_stack.v
// Function
// - four conditional returns on zero set, zero clear, carry set, carry clear
// - false condition just advances program counter by one
// - no return variant alters zero or carry flags
// - load-and-return is one 18-bit word executing in two cycles
// - load-and-return writes immediate to destination while popping and incrementing
// - stack holds thirty nested return addresses
// - stack is strictly last-in first-out, recursion included
// - unconditional return pops, increments, loads program counter
// - call pushes address of the call itself, then loads target
// - stack overflow forces automatic core reset
// - indirect target is low four bits of first register placed above second register
`timescale 1ns/100ps
`default_nettype none
`include "srs_defines.vh"

module srs_stack #(
  parameter DEPTH = `SRS_STACK_DEPTH,
  parameter PTR_W = 5
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // decoded instruction, valid for one cycle per instruction
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [`SRS_PC_WIDTH-1:0] target_addr,
  input wire [`SRS_DATA_WIDTH-1:0] first_reg,
  input wire [`SRS_DATA_WIDTH-1:0] second_reg,
  input wire [3:0] destination_register,
  input wire [`SRS_DATA_WIDTH-1:0] immediate_constant,
  // flags from the alu
  input wire zero_flag,
  input wire carry_flag,
  // program counter and side effects
  output reg [`SRS_PC_WIDTH-1:0] program_counter_q,
  output reg reg_write_q,
  output reg [3:0] reg_addr_q,
  output reg [`SRS_DATA_WIDTH-1:0] reg_data_q,
  output reg [PTR_W-1:0] depth_q,
  output reg core_reset_q,
  output reg phase_q
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // full mark and unit step at pointer width, so compares and steps keep their size
  // single-entry step used by both push and pop
  localparam [PTR_W-1:0] DEPTH_FULL = DEPTH[PTR_W-1:0];
  localparam [PTR_W-1:0] PTR_ONE = {{(PTR_W-1){1'b0}}, 1'b1};
  localparam [PTR_W-1:0] PTR_ZERO = {PTR_W{1'b0}};

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [`SRS_PC_WIDTH-1:0] pc_inc;
    input [`SRS_PC_WIDTH-1:0] a;
    begin
      pc_inc = a + 12'h001;
    end
  endfunction

  // ----------------------------------------------------------------
  // stack storage and decode
  // ----------------------------------------------------------------
  reg [`SRS_PC_WIDTH-1:0] stack_mem [0:DEPTH-1];
  reg [3:0] op_q;
  reg [`SRS_PC_WIDTH-1:0] tgt_q;
  reg zf_q;
  reg cf_q;
  reg [3:0] dst_q;
  reg [`SRS_DATA_WIDTH-1:0] imm_q;
  reg take_ret;
  reg is_ret;
  reg is_call;
  wire [`SRS_PC_WIDTH-1:0] top_addr;
  wire [`SRS_PC_WIDTH-1:0] ind_addr;
  // high for the execute cycle of a call that still fits
  wire push_en;

  assign ind_addr = {first_reg[`SRS_IND_HI_BITS-1:0], second_reg};
  // empty stack: return reads the current address, so it just advances
  assign top_addr = (depth_q != PTR_ZERO) ? stack_mem[depth_q - PTR_ONE] : program_counter_q;

  // flags only read
  // flags are sampled, never written here, so every return variant keeps them
  always @* begin
    is_ret = 1'b0;
    take_ret = 1'b0;
    is_call = 1'b0;
    case (op_q)
      `SRS_OP_RET, `SRS_OP_LDRET: begin
        is_ret = 1'b1;
        take_ret = 1'b1;
      end
      `SRS_OP_RET_Z: begin
        is_ret = 1'b1;
        take_ret = zf_q;
      end
      `SRS_OP_RET_NZ: begin
        is_ret = 1'b1;
        take_ret = ~zf_q;
      end
      `SRS_OP_RET_C: begin
        is_ret = 1'b1;
        take_ret = cf_q;
      end
      `SRS_OP_RET_NC: begin
        is_ret = 1'b1;
        take_ret = ~cf_q;
      end
      `SRS_OP_CALL, `SRS_OP_CALL_IND: begin
        is_call = 1'b1;
      end
      default: begin
        is_ret = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // two-cycle execution
  // ----------------------------------------------------------------
  // capture then execute phase
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_q <= 1'b0;
      op_q <= `SRS_OP_NONE;
      tgt_q <= `SRS_PC_RESET;
      zf_q <= 1'b0;
      cf_q <= 1'b0;
      dst_q <= 4'h0;
      imm_q <= 8'h00;
    end else if (core_reset_q) begin
      phase_q <= 1'b0;
      op_q <= `SRS_OP_NONE;
    end else if (!phase_q) begin
      if (op_valid) begin
        phase_q <= 1'b1;
        op_q <= op_code;
        tgt_q <= (op_code == `SRS_OP_CALL_IND) ? ind_addr : target_addr;
        zf_q <= zero_flag;
        cf_q <= carry_flag;
        dst_q <= destination_register;
        imm_q <= immediate_constant;
      end
    end else begin
      phase_q <= 1'b0;
      op_q <= `SRS_OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // stack storage write
  // ----------------------------------------------------------------
  // a push is refused when full, the overflow path resets the core instead
  assign push_en = phase_q & is_call & ~core_reset_q & (depth_q != DEPTH_FULL);

  // push own address
  // storage sits outside the reset process, so it needs no reset and maps to plain memory
  always @(posedge clk) begin
    if (push_en) begin
      stack_mem[depth_q] <= program_counter_q;
    end
  end

  // ----------------------------------------------------------------
  // program counter and stack pointer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      program_counter_q <= `SRS_PC_RESET;
      depth_q <= {PTR_W{1'b0}};
      core_reset_q <= 1'b0;
      reg_write_q <= 1'b0;
      reg_addr_q <= 4'h0;
      reg_data_q <= 8'h00;
    end else if (core_reset_q) begin
      // one cycle internal reset, stack emptied
      program_counter_q <= `SRS_PC_RESET;
      depth_q <= {PTR_W{1'b0}};
      core_reset_q <= 1'b0;
      reg_write_q <= 1'b0;
    end else begin
      reg_write_q <= 1'b0;
      if (phase_q) begin
        if (is_call) begin
          if (depth_q == DEPTH_FULL) begin
            core_reset_q <= 1'b1;
          end else begin
            depth_q <= depth_q + PTR_ONE;
            program_counter_q <= tgt_q;
          end
        end else if (is_ret && take_ret) begin
          program_counter_q <= pc_inc(top_addr);
          // underflow simply wraps nothing; empty stack stays empty
          if (depth_q != PTR_ZERO) begin
            depth_q <= depth_q - PTR_ONE;
          end
          if (op_q == `SRS_OP_LDRET) begin
            reg_write_q <= 1'b1;
            reg_addr_q <= dst_q;
            reg_data_q <= imm_q;
          end
        end else if (op_q == `SRS_OP_JUMP) begin
          program_counter_q <= tgt_q;
        end else begin
          program_counter_q <= pc_inc(program_counter_q);
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/srs_defines.vh
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// return/call/jump operation codes on op_code
`define SRS_OP_NONE 4'h0
`define SRS_OP_RET 4'h1
`define SRS_OP_RET_Z 4'h2
`define SRS_OP_RET_NZ 4'h3
`define SRS_OP_RET_C 4'h4
`define SRS_OP_RET_NC 4'h5
`define SRS_OP_LDRET 4'h6
`define SRS_OP_CALL 4'h7
`define SRS_OP_CALL_IND 4'h8
`define SRS_OP_JUMP 4'h9

// stack and address geometry
`define SRS_STACK_DEPTH 30
`define SRS_PC_WIDTH 12
`define SRS_DATA_WIDTH 8
`define SRS_IND_HI_BITS 4
`define SRS_INSTR_WIDTH 18
`define SRS_EXEC_CYCLES 2
`define SRS_PC_RESET 12'h000

`endif

//--- sim/srs_stack_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "srs_defines.vh"
module srs_stack_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // instruction side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [11:0] target_addr,
  input wire logic [7:0] immediate_constant,
  input wire logic zero_flag,
  // results
  input wire logic [11:0] program_counter_q,
  input wire logic reg_write_q,
  input wire logic [7:0] reg_data_q,
  input wire logic [4:0] depth_q,
  input wire logic core_reset_q,
  input wire logic phase_q
);
  wire tk = op_valid & ~phase_q & ~core_reset_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_take_exec: assert property (tk |=> phase_q) else $error("phase");
  a_two_cycles: assert property (phase_q |=> !phase_q) else $error("long");
  a_false_ret: assert property (tk && op_code == `SRS_OP_RET_Z && !zero_flag |=> ##1
    program_counter_q == $past(program_counter_q, 2) + 12'h1 && depth_q == $past(depth_q, 2)) else $error("skip");
  a_ret_pop: assert property (tk && op_code == `SRS_OP_RET && depth_q != 5'h0 |=> ##1
    depth_q == $past(depth_q, 2) - 5'h1) else $error("pop");
  a_call_push: assert property (tk && op_code == `SRS_OP_CALL && depth_q < 5'h1E |=> ##1
    depth_q == $past(depth_q, 2) + 5'h1 && program_counter_q == $past(target_addr, 2)) else $error("call");
  a_ldret_write: assert property (tk && op_code == `SRS_OP_LDRET |=> ##1
    reg_write_q && reg_data_q == $past(immediate_constant, 2)) else $error("load");
  a_stray_write: assert property (reg_write_q |->
    $past(tk, 2) && $past(op_code, 2) == `SRS_OP_LDRET) else $error("stray write");
  a_overflow_reset: assert property (tk && op_code == `SRS_OP_CALL && depth_q == 5'h1E |->
    ##[1:2] core_reset_q) else $error("ovf");
  a_depth_bound: assert property (depth_q <= 5'h1E) else $error("deep");
  cover property (tk && op_code == `SRS_OP_LDRET);
  cover property (tk && op_code == `SRS_OP_RET_Z && !zero_flag);
  cover property (depth_q == 5'h1E);
  cover property (core_reset_q);
endmodule
bind srs_stack srs_stack_props u_props (
  .clk(clk),
  .reset(reset),
  .op_valid(op_valid),
  .op_code(op_code),
  .target_addr(target_addr),
  .immediate_constant(immediate_constant),
  .zero_flag(zero_flag),
  .program_counter_q(program_counter_q),
  .reg_write_q(reg_write_q),
  .reg_data_q(reg_data_q),
  .depth_q(depth_q),
  .core_reset_q(core_reset_q),
  .phase_q(phase_q)
);
`default_nettype wire

//--- sim/srs_flag_src.sv
`timescale 1ns/100ps
`default_nettype none
module srs_flag_src (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // execute cycle of the core
  input wire logic phase_q,
  // flags towards the core
  output var logic zero_q,
  output var logic carry_q
);
  // flags move between instructions only, never at a take
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {zero_q, carry_q} <= 2'h0;
    end else if (phase_q) begin
      {zero_q, carry_q} <= 2'($urandom);
    end
  end
endmodule
`default_nettype wire

//--- sim/subroutine_return_stack_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "srs_defines.vh"
module subroutine_return_stack_tb_top;
  logic clk, reset, op_valid, z, cf, zero_flag, carry_flag, reg_write_q, core_reset_q, phase_q;
  logic [3:0] op_code, destination_register, reg_addr_q, o;
  logic [7:0] first_reg, second_reg, immediate_constant, reg_data_q;
  logic [11:0] target_addr, program_counter_q, e;
  logic [11:0] q[$];
  logic [4:0] depth_q;
  logic [31:0] r;
  int n_fail = 0, n_tests = 0, i, k;
  srs_stack uut (
    .clk(clk),
    .reset(reset),
    .op_valid(op_valid),
    .op_code(op_code),
    .target_addr(target_addr),
    .first_reg(first_reg),
    .second_reg(second_reg),
    .destination_register(destination_register),
    .immediate_constant(immediate_constant),
    .zero_flag(zero_flag),
    .carry_flag(carry_flag),
    .program_counter_q(program_counter_q),
    .reg_write_q(reg_write_q),
    .reg_addr_q(reg_addr_q),
    .reg_data_q(reg_data_q),
    .depth_q(depth_q),
    .core_reset_q(core_reset_q),
    .phase_q(phase_q)
  );
  srs_flag_src flags (.clk, .reset, .phase_q, .zero_q(zero_flag), .carry_q(carry_flag));
  task chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function logic taken(input logic [3:0] c, input logic zf, cy);
    case (c)
      `SRS_OP_RET_Z: taken = zf;
      `SRS_OP_RET_NZ: taken = !zf;
      `SRS_OP_RET_C: taken = cy;
      `SRS_OP_RET_NC: taken = !cy;
      default: taken = 1'b1;
    endcase
  endfunction
  // one instruction with fresh random fields, flags caught at the take
  task ex;
    @(posedge clk);
    r = $urandom;
    op_code <= o;
    op_valid <= 1'b1;
    {destination_register, second_reg, first_reg, target_addr} <= r;
    immediate_constant <= r[7:0];
    @(posedge clk);
    z = zero_flag;
    cf = carry_flag;
    op_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  initial begin
    void'($urandom(32'h7EEE4CC3));
    reset = 1'b1;
    {op_valid, op_code, target_addr, first_reg, second_reg, immediate_constant, destination_register} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    e = 12'h000;
    for (k = 0; k < 2; k++) begin
      for (i = 1; i <= 30; i++) begin
        o = `SRS_OP_CALL + 4'($urandom % 2);
        ex;
        q.push_back(e);
        e = o == `SRS_OP_CALL ? target_addr : {first_reg[3:0], second_reg};
        chk(program_counter_q, e);
        chk(depth_q, i);
      end
      if (k == 0) begin
        for (i = 0; i < 400 && q.size() > 0; i++) begin
          o = 4'h1 + 4'($urandom % 6);
          ex;
          e = taken(o, z, cf) ? q.pop_back() + 12'h001 : e + 12'h001;
          chk(program_counter_q, e);
          chk(depth_q, q.size());
          if (o == `SRS_OP_LDRET) begin
            chk({reg_write_q, reg_addr_q, reg_data_q}, {1'b1, destination_register, immediate_constant});
          end else begin
            chk(reg_write_q, 1'b0);
          end
        end
        // a jump and an empty slot leave the stack alone
        o = `SRS_OP_JUMP;
        ex;
        e = target_addr;
        chk({program_counter_q, depth_q}, {e, 5'(q.size())});
        o = `SRS_OP_NONE;
        ex;
        e = e + 12'h001;
        chk({program_counter_q, depth_q}, {e, 5'(q.size())});
      end else begin
        o = `SRS_OP_CALL;
        ex;
        chk(core_reset_q, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk({program_counter_q, depth_q, core_reset_q}, 0);
      end
    end
    summarize;
  end
endmodule
`default_nettype wire
